// file: core/iss_scheduler.sv
// top of the isochronous split transaction scheduler
// assumes the schedule walker presents one descriptor per visit and
// that a fetch port returns the earlier descriptor's buffer pointer
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - isochronous OUT issues starts only, never completes
// - IN: one start, then one to N completes
// - at most two completes wrap into next frame
// - all completes of one IN share one pointer
// - start when phase start and mask bit set
// - complete when phase complete and mask bit set
// - split phase kept as one status bit
// - wrapped completes use earlier descriptor's pointer
// - each payload uses one descriptor's buffer
// - descriptor covers at most one frame
// - OUT one descriptor, wrapped IN two
// - progress vector set per complete, checked first
// - final data retires remaining completes
module iss_scheduler (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         visit_valid,
   output logic                              visit_ready,
   input  wire logic [iss_pkg::FIDX_W-1:0]   frame_index_counter,
   input  wire logic                         d_active,
   input  wire logic                         d_dir_in,
   input  wire logic                         d_split_phase_bit,
   input  wire logic [iss_pkg::MASK_W-1:0]   d_s_mask,
   input  wire logic [iss_pkg::MASK_W-1:0]   d_c_mask,
   input  wire logic [iss_pkg::MASK_W-1:0]   d_c_prog,
   input  wire logic [iss_pkg::PTR_W-1:0]    d_buf_ptr,
   input  wire logic                         d_back_valid,
   input  wire logic [iss_pkg::PTR_W-1:0]    d_back_ptr,
   output logic                              fetch_req,
   output logic [iss_pkg::PTR_W-1:0]         fetch_addr,
   input  wire logic                         fetch_ack,
   input  wire logic [iss_pkg::PTR_W-1:0]    fetch_buf,
   output logic                              tx_start,
   output logic                              tx_complete,
   output logic [iss_pkg::PTR_W-1:0]         tx_ptr,
   input  wire logic                         rsp_valid,
   input  wire logic                         rsp_last,
   output logic                              wb_valid,
   output logic                              wb_active,
   output logic                              wb_split_phase_bit,
   output logic [iss_pkg::MASK_W-1:0]        wb_prog,
   output logic                              wb_missed,
   input  wire logic [iss_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [iss_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [iss_pkg::DATA_W-1:0]        reg_rdata
);
   iss_dec_if dec ();

   iss_pkg::iss_state_e        state;
   iss_pkg::iss_state_e        next_state;
   logic                       enable;
   logic [iss_pkg::CNT_W-1:0]  cnt_start;
   logic [iss_pkg::CNT_W-1:0]  cnt_complete;
   logic [iss_pkg::CNT_W-1:0]  cnt_missed;

   // latched decision for the visit in progress
   logic                       l_start;
   logic                       l_complete;
   logic                       l_missed;
   logic                       l_dir_in;
   logic                       l_active;
   logic                       l_phase;
   logic                       l_more_s;
   logic                       l_more_c;
   logic [iss_pkg::MASK_W-1:0] l_prog;
   logic [iss_pkg::MASK_W-1:0] l_prog_next;
   logic                       take;

   assign dec.active     = d_active;
   assign dec.dir_in     = d_dir_in;
   assign dec.phase      = d_split_phase_bit;
   assign dec.s_mask     = d_s_mask;
   assign dec.c_mask     = d_c_mask;
   assign dec.c_prog     = d_c_prog;
   assign dec.back_valid = d_back_valid;
   assign dec.uframe     = frame_index_counter[iss_pkg::UF_W-1:0];
   assign dec.enable     = enable;

   iss_split_decider u_dec (
      .d (dec)
   );

   assign take = visit_valid & visit_ready;

   // sequencing of one descriptor visit
   always_comb
   begin
      next_state = state;
      case (state)
         iss_pkg::ISS_IDLE:
         begin
            if (take)
            begin
               if (dec.do_complete & dec.wrap)
                  next_state = iss_pkg::ISS_FETCH;
               else if (dec.do_start | dec.do_complete)
                  next_state = iss_pkg::ISS_SEND;
               else
                  next_state = iss_pkg::ISS_WB;
            end
         end

         iss_pkg::ISS_FETCH:
         begin
            if (fetch_ack)
               next_state = iss_pkg::ISS_SEND;
         end

         iss_pkg::ISS_SEND:
         begin
            if (l_complete)
               next_state = iss_pkg::ISS_RSP;
            else
               next_state = iss_pkg::ISS_WB;
         end

         iss_pkg::ISS_RSP:
         begin
            if (rsp_valid)
               next_state = iss_pkg::ISS_WB;
         end

         iss_pkg::ISS_WB:
            next_state = iss_pkg::ISS_IDLE;
         default:
            next_state = iss_pkg::ISS_IDLE;
      endcase
   end

   // visit state
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state <= iss_pkg::ISS_IDLE;
      else
         state <= next_state;
   end

   // visits are accepted only while idle
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         visit_ready <= 1'b0;
      else
         visit_ready <= (next_state == iss_pkg::ISS_IDLE);
   end

   // capture of the descriptor and the decision
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         l_start     <= 1'b0;
         l_complete  <= 1'b0;
         l_missed    <= 1'b0;
         l_dir_in    <= 1'b0;
         l_active    <= 1'b0;
         l_phase     <= iss_pkg::PHASE_START;
         l_more_s    <= 1'b0;
         l_more_c    <= 1'b0;
         l_prog      <= '0;
         l_prog_next <= '0;
      end
      else if (take)
      begin
         l_start     <= dec.do_start;
         l_complete  <= dec.do_complete;
         l_missed    <= dec.missed;
         l_dir_in    <= d_dir_in;
         l_active    <= d_active;
         l_phase     <= d_split_phase_bit;
         l_more_s    <= dec.more_s;
         l_more_c    <= dec.more_c;
         l_prog      <= d_c_prog;
         l_prog_next <= dec.prog_next;
      end
   end

   // earlier descriptor reached through the back pointer
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         fetch_req  <= 1'b0;
         fetch_addr <= '0;
      end
      else if (take & dec.do_complete & dec.wrap)
      begin
         fetch_req  <= 1'b1;
         fetch_addr <= d_back_ptr;
      end
      else if (fetch_ack)
         fetch_req  <= 1'b0;
   end

   // one pointer per payload: own buffer, or the earlier one's
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         tx_ptr <= '0;
      else if (take)
         tx_ptr <= d_buf_ptr;
      else if (state == iss_pkg::ISS_FETCH && fetch_ack)
         tx_ptr <= fetch_buf;
   end

   // issue strobes, one cycle each
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_start    <= 1'b0;
         tx_complete <= 1'b0;
      end
      else
      begin
         // on entry to send only
         tx_start    <= (next_state == iss_pkg::ISS_SEND)
                        & (state != iss_pkg::ISS_SEND)
                        & (take ? dec.do_start : l_start);

         tx_complete <= (next_state == iss_pkg::ISS_SEND)
                        & (state != iss_pkg::ISS_SEND)
                        & (take ? dec.do_complete
                                : l_complete);
      end
   end

   // descriptor state written back at the end of a visit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wb_valid           <= 1'b0;
         wb_active          <= 1'b0;
         wb_split_phase_bit <= iss_pkg::PHASE_START;
         wb_prog            <= '0;
         wb_missed          <= 1'b0;
      end
      else
      begin
         wb_valid <= (next_state == iss_pkg::ISS_WB);

         if (next_state == iss_pkg::ISS_WB)
         begin
            wb_missed          <= l_missed;
            wb_prog            <= l_prog;
            wb_active          <= l_active;
            wb_split_phase_bit <= l_phase;
            if (take)
            begin
               // nothing to issue: state handed back unchanged, except active cleared on a missed complete
               wb_missed          <= dec.missed;
               wb_prog            <= d_c_prog;
               wb_active          <= d_active & ~dec.missed;
               wb_split_phase_bit <= d_split_phase_bit;
            end
            else if (l_start & l_dir_in)
               // single start, then completes
               wb_split_phase_bit <= iss_pkg::PHASE_COMPLETE;
            else if (l_start)
               // OUT stays active until its last start
               wb_active <= l_more_s;
            else if (l_complete)
            begin
               wb_prog   <= l_prog_next;
               // final data retires the remaining completes
               wb_active <= l_more_c & ~rsp_last;
            end
         end
      end
   end

   // control register enable bit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         enable <= iss_pkg::CTRL_EN_RST;
      else if (reg_wr && reg_addr == iss_pkg::REG_CTRL)
         enable <= reg_wdata[iss_pkg::CTRL_EN_BIT];
   end

   // event counters
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_start    <= iss_pkg::CNT_RST;
         cnt_complete <= iss_pkg::CNT_RST;
         cnt_missed   <= iss_pkg::CNT_RST;
      end
      else
      begin
         if (tx_start)
            cnt_start <= cnt_start + 1'b1;

         if (tx_complete)
            cnt_complete <= cnt_complete + 1'b1;

         if (wb_valid & wb_missed)
            cnt_missed <= cnt_missed + 1'b1;
      end
   end

   // register reads
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            iss_pkg::REG_CTRL:
               reg_rdata <= {{(iss_pkg::DATA_W-1){1'b0}}, enable};
            iss_pkg::REG_STARTS:
               reg_rdata <= {{(iss_pkg::DATA_W-iss_pkg::CNT_W){1'b0}},
                             cnt_start};
            iss_pkg::REG_COMPLETE:
               reg_rdata <= {{(iss_pkg::DATA_W-iss_pkg::CNT_W){1'b0}},
                             cnt_complete};
            iss_pkg::REG_MISSED:
               reg_rdata <= {{(iss_pkg::DATA_W-iss_pkg::CNT_W){1'b0}},
                             cnt_missed};
            default:
               reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end
endmodule // iss_scheduler

// file: core/iss_split_decider.sv
// split decision for one descriptor in the current micro-frame
// assumes the descriptor fields are steady while the top samples
`timescale 1ns/1ps
module iss_split_decider (
   iss_dec_if.dec d
);
   // one-hot select of a micro-frame
   function automatic logic [iss_pkg::MASK_W-1:0] uf_bit(
      input logic [iss_pkg::UF_W-1:0] uf
   );
      uf_bit = iss_pkg::MASK_W'(1) << uf;
   endfunction

   logic [iss_pkg::MASK_W-1:0] sel;
   logic [iss_pkg::MASK_W-1:0] below;
   logic [iss_pkg::MASK_W-1:0] above;
   logic                       s_hit;
   logic                       c_hit;
   logic                       prog_ok;
   logic                       go;

   // masks of micro-frames before and after the current one
   genvar gi;
   generate
      for (gi = 0; gi < iss_pkg::MASK_W; gi++)
      begin : g_rel
         assign below[gi] = (gi < d.uframe);
         assign above[gi] = (gi > d.uframe);
      end
   endgenerate

   assign sel     = uf_bit(d.uframe);
   assign go      = d.enable & d.active;
   assign s_hit   = |(d.s_mask & sel);
   assign c_hit   = |(d.c_mask & sel);
   // every earlier scheduled complete must already be done
   assign prog_ok = ((d.c_prog & d.c_mask & below)
                     == (d.c_mask & below));
   // wrapped completes only reach micro-frames 0 and 1
   assign d.wrap  = d.back_valid
                    & (d.uframe <= iss_pkg::WRAP_LAST_UF);

   assign d.do_start    = go & (d.phase == iss_pkg::PHASE_START)
                          & s_hit;
   // completes only for IN endpoints, gated by the phase bit
   assign d.do_complete = go & d.dir_in
                          & (d.phase == iss_pkg::PHASE_COMPLETE)
                          & c_hit & prog_ok
                          & (~d.back_valid | d.wrap);
   assign d.missed      = go & d.dir_in
                          & (d.phase == iss_pkg::PHASE_COMPLETE)
                          & c_hit & ~prog_ok;
   assign d.more_s      = |(d.s_mask & above);
   assign d.more_c      = |(d.c_mask & above);
   assign d.prog_next   = d.c_prog | sel;
endmodule // iss_split_decider

// file: include/iss_dec_if.sv
// carrier between scheduler top and split decider
// assumes both ends share clk_sys; contents are combinational
`timescale 1ns/1ps
interface iss_dec_if;
   logic                           active;
   logic                           dir_in;
   logic                           phase;
   logic [iss_pkg::MASK_W-1:0]     s_mask;
   logic [iss_pkg::MASK_W-1:0]     c_mask;
   logic [iss_pkg::MASK_W-1:0]     c_prog;
   logic                           back_valid;
   logic [iss_pkg::UF_W-1:0]       uframe;
   logic                           enable;
   logic                           do_start;
   logic                           do_complete;
   logic                           missed;
   logic                           wrap;
   logic                           more_s;
   logic                           more_c;
   logic [iss_pkg::MASK_W-1:0]     prog_next;

   modport top (
      output active, dir_in, phase, s_mask, c_mask, c_prog,
             back_valid, uframe, enable,
      input  do_start, do_complete, missed, wrap, more_s, more_c,
             prog_next
   );
   modport dec (
      input  active, dir_in, phase, s_mask, c_mask, c_prog,
             back_valid, uframe, enable,
      output do_start, do_complete, missed, wrap, more_s, more_c,
             prog_next
   );
endinterface

// file: include/iss_pkg.sv
// constants for the isochronous split transaction scheduler
// assumes one clock domain; no module state lives here
package iss_pkg;
   localparam int UF_W       = 3;
   localparam int MASK_W     = 8;
   localparam int FIDX_W     = 14;
   localparam int PTR_W      = 32;
   localparam int DATA_W     = 32;
   localparam int ADDR_W     = 4;
   localparam int CNT_W      = 16;

   // split phase bit encodings
   localparam logic PHASE_START    = 1'b0;
   localparam logic PHASE_COMPLETE = 1'b1;

   // wrapped completes may fall only in host micro-frames 0 and 1
   localparam logic [UF_W-1:0] WRAP_LAST_UF = 3'h1;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STARTS   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_COMPLETE = 4'h8;
   localparam logic [ADDR_W-1:0] REG_MISSED   = 4'hc;

   localparam int        CTRL_EN_BIT  = 0;
   localparam logic      CTRL_EN_RST  = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

   typedef enum logic [2:0] {
      ISS_IDLE,
      ISS_FETCH,
      ISS_SEND,
      ISS_RSP,
      ISS_WB
   } iss_state_e;
endpackage

// file: testbench/iss_scheduler_assertions.sv
// concurrent checks on the split scheduler top ports
// assumes one clock clk_sys and synchronous active-high rst
`timescale 1ns/1ps
module iss_scheduler_assertions (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        visit_valid,
   input wire logic        visit_ready,
   input wire logic [13:0] frame_index_counter,
   input wire logic        d_active,
   input wire logic        d_dir_in,
   input wire logic        d_split_phase_bit,
   input wire logic [7:0]  d_s_mask,
   input wire logic [7:0]  d_c_mask,
   input wire logic [7:0]  d_c_prog,
   input wire logic [31:0] d_buf_ptr,
   input wire logic        d_back_valid,
   input wire logic [31:0] d_back_ptr,
   input wire logic        fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic        fetch_ack,
   input wire logic [31:0] fetch_buf,
   input wire logic        tx_start,
   input wire logic        tx_complete,
   input wire logic [31:0] tx_ptr,
   input wire logic        rsp_valid,
   input wire logic        rsp_last,
   input wire logic        wb_valid,
   input wire logic        wb_active,
   input wire logic [7:0]  wb_prog,
   input wire logic        wb_missed,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr
);
   logic        en, st_q, cp_q, wr_q, ms_q;
   logic [2:0]  uf_q;
   logic [7:0]  cm_q;
   logic [31:0] buf_q;
   wire  [2:0]  uf = frame_index_counter[2:0];
   wire         take = visit_valid && visit_ready;
   wire         late = d_back_valid && uf > iss_pkg::WRAP_LAST_UF;
   wire         ok_c = take && en && d_active && d_dir_in && d_c_mask[uf]
                       && d_split_phase_bit == iss_pkg::PHASE_COMPLETE;
   wire         prog_ok = ((d_c_mask & ((8'h01 << uf) - 8'h01))
                          & ~d_c_prog) == 8'h00;
   wire         go_c = ok_c && prog_ok && !late;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         en <= iss_pkg::CTRL_EN_RST;
      else if (reg_wr && reg_addr == iss_pkg::REG_CTRL)
         en <= reg_wdata[iss_pkg::CTRL_EN_BIT];
   end

   always_ff @(posedge clk_sys)
   begin
      st_q <= !rst && take && en && d_active && d_s_mask[uf]
              && d_split_phase_bit == iss_pkg::PHASE_START;
      cp_q <= !rst && go_c && !d_back_valid;
      wr_q <= !rst && go_c && d_back_valid;
      ms_q <= !rst && ok_c && !prog_ok && !late;
      if (take)
      begin
         uf_q  <= uf;
         cm_q  <= d_c_mask;
         buf_q <= d_buf_ptr;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_wrap_fetch;
      fetch_req && fetch_addr == $past(d_back_ptr);
   endsequence
   sequence s_rsp_wb;
      rsp_valid ##1 wb_valid;
   endsequence

   a_start_exact: assert property (tx_start == st_q)
      else $error("start pulse wrong");
   a_complete_now: assert property (cp_q |-> tx_complete && tx_ptr == buf_q)
      else $error("complete or pointer wrong");
   a_complete_cause: assert property (tx_complete |-> cp_q || $past(fetch_ack))
      else $error("complete without cause");
   a_wrap_fetch: assert property (wr_q |-> s_wrap_fetch)
      else $error("back pointer not fetched");
   a_wrap_ptr: assert property (fetch_ack && fetch_req |=> tx_complete && tx_ptr == $past(fetch_buf))
      else $error("wrapped complete pointer wrong");
   a_wrap_limit: assert property (take && late |=> (!fetch_req && !tx_complete)[*2])
      else $error("late wrapped complete issued");
   a_missed_flag: assert property (ms_q |-> wb_valid && wb_missed && !wb_active && !tx_complete)
      else $error("skipped complete not reported");
   a_prog_mark: assert property (s_rsp_wb |-> wb_prog[uf_q] && wb_active == ((|(cm_q >> uf_q >> 1)) && !$past(rsp_last)))
      else $error("progress or retire state wrong");
   a_out_no_cplt: assert property (take && !d_dir_in |=> !tx_complete[*3])
      else $error("complete for out endpoint");
   a_one_start: assert property (tx_start |=> (!tx_start && !tx_complete)[*2])
      else $error("extra split after start");
endmodule // iss_scheduler_assertions

bind iss_scheduler iss_scheduler_assertions u_iss_scheduler_assertions (
   .clk_sys, .rst, .visit_valid, .visit_ready, .frame_index_counter,
   .d_active, .d_dir_in, .d_split_phase_bit, .d_s_mask, .d_c_mask,
   .d_c_prog, .d_buf_ptr, .d_back_valid, .d_back_ptr, .fetch_req,
   .fetch_addr, .fetch_ack, .fetch_buf, .tx_start, .tx_complete, .tx_ptr,
   .rsp_valid, .rsp_last, .wb_valid, .wb_active, .wb_prog, .wb_missed,
   .reg_addr, .reg_wdata, .reg_wr
);

// file: testbench/iss_scheduler_bench.sv
// self-checking bench for the isochronous split scheduler
// assumes the far-side model answers fetches and completes
`timescale 1ns/1ps
module iss_scheduler_bench;
   localparam logic [31:0] BUF_XOR  = 32'h0000_5a00;
   localparam logic [31:0] BUF_OWN  = 32'h8000_0100;
   localparam logic [31:0] BUF_BACK = 32'h8000_0200;
   logic        clk_sys = 1'b0, rst = 1'b1, visit_valid = 1'b0;
   logic [13:0] frame_index_counter = 14'h0000;
   logic        d_active = 1'b0, d_dir_in = 1'b0, d_split_phase_bit = 1'b0;
   logic [7:0]  d_s_mask = 8'h00, d_c_mask = 8'h00, d_c_prog = 8'h00;
   logic [31:0] d_buf_ptr = BUF_OWN, d_back_ptr = BUF_BACK;
   logic        d_back_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0, dly = 4'h0;
   logic [31:0] reg_wdata = 32'h0, fetch_addr, fetch_buf, tx_ptr, reg_rdata;
   logic        last_cmd = 1'b0, visit_ready, fetch_req, fetch_ack;
   logic        tx_start, tx_complete, rsp_valid, rsp_last, wb_valid;
   logic        wb_active, wb_split_phase_bit, wb_missed;
   logic [7:0]  wb_prog;
   int          err_count = 0, comparisons = 0, n_st = 0, n_cp = 0;

   always #5 clk_sys = ~clk_sys;

   iss_scheduler u_iss_scheduler (
      .clk_sys, .rst, .visit_valid, .visit_ready, .frame_index_counter,
      .d_active, .d_dir_in, .d_split_phase_bit, .d_s_mask, .d_c_mask,
      .d_c_prog, .d_buf_ptr, .d_back_valid, .d_back_ptr, .fetch_req,
      .fetch_addr, .fetch_ack, .fetch_buf, .tx_start, .tx_complete, .tx_ptr,
      .rsp_valid, .rsp_last, .wb_valid, .wb_active, .wb_split_phase_bit,
      .wb_prog, .wb_missed, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata
   );
   iss_tt_model #(.BUF_XOR(BUF_XOR)) u_iss_tt_model (
      .clk_sys, .rst, .dly, .last_cmd, .fetch_req, .fetch_addr, .fetch_ack,
      .fetch_buf, .tx_complete, .rsp_valid, .rsp_last
   );

   always @(posedge clk_sys)
   begin
      n_st <= n_st + int'(tx_start);
      n_cp <= n_cp + int'(tx_complete);
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(posedge clk_sys);
      chk("reg_rdata", exp, reg_rdata);
   endtask

   // one visit; counts its starts and completes
   task automatic visit(input logic act, din, ph, input logic [7:0] sm,
                        cm, pg, input logic [2:0] uf, input logic bv,
                        output int st, cp);
      int s0, c0, k;
      s0 = n_st;
      c0 = n_cp;
      d_active            <= act;
      d_dir_in            <= din;
      d_split_phase_bit   <= ph;
      d_s_mask            <= sm;
      d_c_mask            <= cm;
      d_c_prog            <= pg;
      d_back_valid        <= bv;
      frame_index_counter <= {11'h02a, uf};
      visit_valid         <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk_sys);
         if (visit_ready) break;
      end
      visit_valid <= 1'b0;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk_sys);
         if (wb_valid) break;
      end
      if (!wb_valid) err_count++;
      @(posedge clk_sys);
      st = n_st - s0;
      cp = n_cp - c0;
   endtask

   task automatic s_registers;
      reg_check(iss_pkg::REG_CTRL, 32'h0);
      reg_write(iss_pkg::REG_STARTS, 32'h0000_ffff);
      reg_check(iss_pkg::REG_STARTS, 32'h0);
      reg_check(4'h2, 32'h0);
      reg_write(iss_pkg::REG_CTRL, 32'h1);
      reg_check(iss_pkg::REG_CTRL, 32'h1);
   endtask

   task automatic s_out_split;
      int st, cp;
      visit(1, 0, 0, 8'h0c, 8'h00, 8'h00, 3'h2, 0, st, cp);
      chk("out_starts", 1, st);
      chk("out_ptr", BUF_OWN, tx_ptr);
      chk("out_active", 1, wb_active);
      visit(1, 0, 0, 8'h0c, 8'h00, 8'h00, 3'h3, 0, st, cp);
      chk("out_done", 0, wb_active);
      visit(1, 0, 1, 8'h00, 8'hff, 8'hff, 3'h4, 0, st, cp);
      chk("out_completes", 0, cp);
   endtask

   task automatic s_in_start;
      int st, cp;
      visit(1, 1, 0, 8'h01, 8'h3c, 8'h00, 3'h1, 0, st, cp);
      chk("in_masked", 0, st);
      chk("in_phase_kept", 0, wb_split_phase_bit);
      visit(1, 1, 0, 8'h01, 8'h3c, 8'h00, 3'h0, 0, st, cp);
      chk("in_starts", 1, st);
      chk("in_phase", 1, wb_split_phase_bit);
      chk("in_active", 1, wb_active);
   endtask

   task automatic s_in_complete;
      int st, cp;
      dly      <= 4'h2;
      last_cmd <= 1'b0;
      visit(1, 1, 1, 8'h01, 8'h3c, 8'h04, 3'h3, 0, st, cp);
      chk("cs_count", 1, cp);
      chk("cs_ptr", BUF_OWN, tx_ptr);
      chk("cs_prog", 8'h0c, wb_prog);
      chk("cs_active", 1, wb_active);
      last_cmd <= 1'b1;
      visit(1, 1, 1, 8'h01, 8'h3c, 8'h0c, 3'h4, 0, st, cp);
      chk("final_active", 0, wb_active);
      chk("final_prog", 8'h1c, wb_prog);
      visit(1, 1, 1, 8'h01, 8'h3c, 8'h00, 3'h4, 0, st, cp);
      chk("miss_count", 0, cp);
      chk("miss_flag", 1, wb_missed);
      chk("miss_active", 0, wb_active);
      visit(1, 1, 1, 8'h01, 8'h3c, 8'h3c, 3'h6, 0, st, cp);
      chk("cs_unmasked", 0, cp);
   endtask

   task automatic s_wrap;
      int st, cp;
      dly      <= 4'h3;
      last_cmd <= 1'b0;
      visit(1, 1, 1, 8'h00, 8'h03, 8'h00, 3'h0, 1, st, cp);
      chk("wrap_count", 1, cp);
      chk("wrap_ptr", BUF_BACK ^ BUF_XOR, tx_ptr);
      chk("wrap_prog", 8'h01, wb_prog);
      visit(1, 1, 1, 8'h00, 8'h03, 8'h01, 3'h1, 1, st, cp);
      chk("wrap2_ptr", BUF_BACK ^ BUF_XOR, tx_ptr);
      visit(1, 1, 1, 8'h00, 8'h04, 8'h03, 3'h2, 1, st, cp);
      chk("wrap_late", 0, cp);
      chk("wrap_late_miss", 0, wb_missed);
   endtask

   task automatic s_inactive;
      int st, cp;
      visit(0, 1, 0, 8'hff, 8'hff, 8'h00, 3'h0, 0, st, cp);
      chk("idle_starts", 0, st);
      chk("idle_completes", 0, cp);
   endtask

   task automatic summarize;
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      s_registers();
      s_out_split();
      s_in_start();
      s_in_complete();
      s_wrap();
      s_inactive();
      reg_check(iss_pkg::REG_STARTS, 32'h3);
      reg_check(iss_pkg::REG_COMPLETE, 32'h4);
      reg_check(iss_pkg::REG_MISSED, 32'h1);
      summarize();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      summarize();
   end
endmodule // iss_scheduler_bench

// file: testbench/iss_tt_model.sv
// far side: descriptor fetch port and hub translator answers
// assumes fetch_req is held until acknowledged
`timescale 1ns/1ps
module iss_tt_model #(
   parameter logic [31:0] BUF_XOR = 32'h0000_5a00
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [3:0]  dly,
   input  wire logic        last_cmd,
   input  wire logic        fetch_req,
   input  wire logic [31:0] fetch_addr,
   output      logic        fetch_ack,
   output      logic [31:0] fetch_buf,
   input  wire logic        tx_complete,
   output      logic        rsp_valid,
   output      logic        rsp_last
);
   logic [3:0] fcnt, rcnt;
   logic       rpend;

   always_ff @(posedge clk_sys)
   begin
      if (rst || !fetch_req || fetch_ack)
      begin
         fcnt      <= 4'h0;
         fetch_ack <= 1'b0;
         fetch_buf <= rst ? 32'h0 : ~fetch_buf;
      end
      else if (fcnt == dly)
      begin
         fetch_ack <= 1'b1;
         fetch_buf <= fetch_addr ^ BUF_XOR;
      end
      else
         fcnt <= fcnt + 4'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      rsp_valid <= 1'b0;
      rsp_last  <= rst ? 1'b0 : ~rsp_last;
      if (rst)
         rpend <= 1'b0;
      else if (tx_complete)
      begin
         rpend <= 1'b1;
         rcnt  <= 4'h0;
      end
      else if (rpend && rcnt == dly)
      begin
         rpend     <= 1'b0;
         rsp_valid <= 1'b1;
         rsp_last  <= last_cmd;
      end
      else if (rpend)
         rcnt <= rcnt + 4'h1;
   end
endmodule // iss_tt_model
